// [inc/mdac_regs.vh]
// Register map, field positions, reset values and timing counts of the
// multimeter converter control block.
// Assumes inclusion by bare name from the design file.
`ifndef MDAC_REGS_VH
`define MDAC_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MDAC_OFS_CLOCK 8'h00
`define MDAC_OFS_CONF 8'h04
`define MDAC_OFS_FUNC 8'h08
`define MDAC_OFS_INIT 8'h0c
`define MDAC_OFS_IE 8'h10
`define MDAC_OFS_IF 8'h14
`define MDAC_OFS_COMB 8'h18
`define MDAC_OFS_LPHP 8'h1c
`define MDAC_OFS_AC1 8'h20
`define MDAC_OFS_AC2 8'h24
`define MDAC_OFS_DCMAX 8'h28
`define MDAC_OFS_DCMIN 8'h2c
`define MDAC_OFS_ACMAX1 8'h30
`define MDAC_OFS_ACMAX2 8'h34
`define MDAC_OFS_ACMIN1 8'h38
`define MDAC_OFS_ACMIN2 8'h3c
`define MDAC_OFS_CLKSTAT 8'h40

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MDAC_CLK_DEBUG_RUN 8
`define MDAC_CONF_SQRT 7
`define MDAC_CONF_PATH 6
`define MDAC_CONF_PEAK 5
`define MDAC_CONF_MEAN 4
`define MDAC_CONF_MODULE_ENABLE 0
`define MDAC_INIT_PEAK_CLR 9
`define MDAC_INIT_FILT_CLR 8
`define MDAC_INIT_RUN 1

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define MDAC_CLOCK_MASK 16'h0133
`define MDAC_CONF_MASK 16'h3ff1
`define MDAC_FUNC_MASK 16'h007f
`define MDAC_IE_MASK 16'h07ff
`define MDAC_DCMAX_RST 16'h8000
`define MDAC_DCMIN_RST 16'h7fff
`define MDAC_ZERO16 16'h0000

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
// Peak clear lasts 4 us of the 200 MHz clock.
`define MDAC_PEAK_CLR_CYC 10'h320
`define MDAC_FILT_CLR_CYC 5'h10

`endif

// [rtl/mdac_control.v]
// Control, configuration and event flags of a multimeter converter.
// Assumes an AXI4-Lite master, a filter chain that pulses stage results,
// and a continuity level from the analogue side on another clock.
// Operation
// - Each stage completion sets its own done flag; software clears by writing 1.
// - Comb, lowpass, highpass load while done flag set raises overwrite flag.
// - Averaging and sqrt stages share AC result, each own overwrite flag.
// - Any continuity change sets the continuity flag; write 1 clears it.
// - Conversion continues after an overwrite; new result replaces the old.
// - Overwrite decided from done flag only, not from result reads.
// - Interrupt request high only while an enabled flag is set.
// - Debug-run bit 8 keeps the operating clock running in debug mode.
// - Source field picks one of four clocks; divide ratio depends on source.
// - Clock register writes ignored while module enable is 1.
// - Averaging field selects 256, 512, 1024 or 2048 samples.
// - Oversampling field selects 16 to 16384; codes 0xb-0xf reserved.
// - Sqrt enable routes sqrt outputs to AC result, else averaging outputs.
// - Path select 1 uses lowpass, 0 highpass; shared register holds it.
// - Peak hold stores new max or min; DC 16-bit, AC paired registers.
// - Peak hold off freezes peak registers; peak clear takes 4 us.
// - Mean type 1 averages squares, 0 averages absolute values.
// - Module enable starts and stops the operating clock supply.
// - Filter clear wipes filter state and results; reads 1 while clearing.
// - Run bit starts conversion at 1 and stops it at 0.
// - Peak clear wipes all peak results; reads 1 until done.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mdac_regs.vh"

module mdac_control (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire debug_mode,
    input wire [3:0] osc_running,
    input wire comb_result_valid,
    input wire [15:0] comb_result,
    input wire lowpass_result_valid,
    input wire highpass_result_valid,
    input wire [15:0] filter_result,
    input wire average_result_valid,
    input wire [31:0] average_result,
    input wire sqrt_result_valid,
    input wire [31:0] sqrt_result,
    input wire [4:0] stage_busy,
    input wire ac_mode,
    input wire continuity_in,
    output reg operating_clock_enable,
    output reg [1:0] clock_source_sel,
    output reg [4:0] clock_divide_log2,
    output reg conversion_run,
    output reg filter_clear_active,
    output reg [1:0] average_count_sel,
    output reg [3:0] oversample_ratio_sel,
    output reg sqrt_stage_enable,
    output reg filter_path_select,
    output reg mean_type_select,
    output reg [3:0] function_select,
    output reg [2:0] range_select,
    output reg irq
);

// ------
// Registers
// ------
reg debug_run;
reg [1:0] clock_divide_sel;
reg peak_enable;
reg module_enable;
reg [10:0] irq_enable;
reg [10:0] flags;
reg [15:0] comb_data;
reg [15:0] lphp_data;
reg [31:0] ac_data;
reg [15:0] dc_max;
reg [15:0] dc_min;
reg [31:0] ac_max;
reg [31:0] ac_min;
reg peak_clear;
reg [9:0] peak_count;
reg [4:0] filt_count;
reg cont_meta;
reg cont_sync;
reg cont_prev;
reg [3:0] osc_meta;
reg [3:0] osc_sync;
reg [7:0] wr_addr;
reg [31:0] wr_data;
reg [3:0] wr_strb;
reg have_aw;
reg have_w;

wire [7:0] aw_addr = s_axi_awvalid && s_axi_awready ? s_axi_awaddr
                                                    : wr_addr;
wire aw_ok = have_aw || (s_axi_awvalid && s_axi_awready);
wire w_ok = have_w || (s_axi_wvalid && s_axi_wready);
wire do_write = aw_ok && w_ok && !s_axi_bvalid;
wire [31:0] wd = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wr_data;
wire [3:0] ws = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wr_strb;
wire [15:0] wmask = {{8{ws[1]}}, {8{ws[0]}}};
wire [15:0] wv = wd[15:0] & wmask;

wire wr_clock = do_write && aw_addr == `MDAC_OFS_CLOCK;
wire wr_conf = do_write && aw_addr == `MDAC_OFS_CONF;
wire wr_func = do_write && aw_addr == `MDAC_OFS_FUNC;
wire wr_init = do_write && aw_addr == `MDAC_OFS_INIT;
wire wr_ie = do_write && aw_addr == `MDAC_OFS_IE;
wire wr_if = do_write && aw_addr == `MDAC_OFS_IF;

// ------
// Event sources
// ------
// Flag order: 0 comb, 1 lowpass, 2 highpass, 3 average, 4 comb ovr,
// 5 lowpass ovr, 6 highpass ovr, 7 average ovr, 8 sqrt, 9 sqrt ovr,
// 10 continuity.
wire lp_load = lowpass_result_valid && filter_path_select;
wire hp_load = highpass_result_valid && !filter_path_select;
wire av_load = average_result_valid && !sqrt_stage_enable;
wire sq_load = sqrt_result_valid && sqrt_stage_enable;
wire cont_change = cont_sync ^ cont_prev;
wire [10:0] set_ev;
assign set_ev[0] = comb_result_valid;
assign set_ev[1] = lp_load;
assign set_ev[2] = hp_load;
assign set_ev[3] = av_load;
assign set_ev[4] = comb_result_valid && flags[0];
assign set_ev[5] = lp_load && flags[1];
assign set_ev[6] = hp_load && flags[2];
assign set_ev[7] = av_load && flags[3];
assign set_ev[8] = sq_load;
assign set_ev[9] = sq_load && flags[8];
assign set_ev[10] = cont_change;

// ------
// Event flags, one per generate entry
// ------
genvar gi;
generate
    for (gi = 0; gi < 11; gi = gi + 1) begin : g_flag
        always @(posedge aclk) begin
            if (!aresetn || filter_clear_active && gi < 10) begin
                flags[gi] <= 1'b0;
            end else if (set_ev[gi]) begin
                flags[gi] <= 1'b1;
            end else if (wr_if && wv[gi]) begin
                flags[gi] <= 1'b0;
            end
        end
    end
endgenerate

// ------
// Synchronisers for asynchronous inputs
// ------
always @(posedge aclk) begin
    if (!aresetn) begin
        cont_meta <= 1'b0;
        cont_sync <= 1'b0;
        cont_prev <= 1'b0;
        osc_meta <= 4'h0;
        osc_sync <= 4'h0;
    end else begin
        cont_meta <= continuity_in;
        cont_sync <= cont_meta;
        cont_prev <= cont_sync;
        osc_meta <= osc_running;
        osc_sync <= osc_meta;
    end
end

// ------
// Control registers
// ------
always @(posedge aclk) begin
    if (!aresetn) begin
        debug_run <= 1'b0;
        clock_divide_sel <= 2'h0;
        clock_source_sel <= 2'h0;
        average_count_sel <= 2'h0;
        oversample_ratio_sel <= 4'h0;
        sqrt_stage_enable <= 1'b0;
        filter_path_select <= 1'b0;
        peak_enable <= 1'b0;
        mean_type_select <= 1'b0;
        module_enable <= 1'b0;
        function_select <= 4'h0;
        range_select <= 3'h0;
        conversion_run <= 1'b0;
        irq_enable <= 11'h000;
    end else begin
        if (wr_clock && !module_enable) begin
            debug_run <= wv[`MDAC_CLK_DEBUG_RUN];
            clock_divide_sel <= wv[5:4];
            clock_source_sel <= wv[1:0];
        end
        if (wr_conf) begin
            average_count_sel <= wv[13:12];
            if (wv[11:8] <= 4'ha) begin
                oversample_ratio_sel <= wv[11:8];
            end
            sqrt_stage_enable <= wv[`MDAC_CONF_SQRT];
            filter_path_select <= wv[`MDAC_CONF_PATH];
            peak_enable <= wv[`MDAC_CONF_PEAK];
            mean_type_select <= wv[`MDAC_CONF_MEAN];
            module_enable <= wv[`MDAC_CONF_MODULE_ENABLE];
        end
        if (wr_func) begin
            range_select <= wv[6:4];
            function_select <= wv[3:0];
        end
        if (wr_init) begin
            conversion_run <= wv[`MDAC_INIT_RUN];
        end
        if (wr_ie) begin
            irq_enable <= wv[10:0];
        end
    end
end

// ------
// Clock supply, divider code and interrupt output
// ------
always @(posedge aclk) begin
    if (!aresetn) begin
        operating_clock_enable <= 1'b0;
        clock_divide_log2 <= 5'h00;
        irq <= 1'b0;
    end else begin
        operating_clock_enable <= module_enable &&
            (!debug_mode || debug_run);
        // Code follows the written fields in the same edge as the source.
        if (wr_clock && !module_enable) begin
            if (wv[5:4] == 2'h0) begin
                clock_divide_log2 <= 5'h00;
            end else if (wv[1:0] == 2'h0) begin
                clock_divide_log2 <= {3'h0, wv[5:4]};
            end else begin
                clock_divide_log2 <= {3'h0, wv[5:4]} + 5'h01;
            end
        end
        irq <= |(flags & irq_enable);
    end
end

// ----------------------------------------------------------------------
// Filter clear and result registers
// ----------------------------------------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        filter_clear_active <= 1'b0;
        filt_count <= 5'h00;
        comb_data <= `MDAC_ZERO16;
        lphp_data <= `MDAC_ZERO16;
        ac_data <= 32'h00000000;
    end else if (filter_clear_active) begin
        comb_data <= `MDAC_ZERO16;
        lphp_data <= `MDAC_ZERO16;
        ac_data <= 32'h00000000;
        filt_count <= filt_count - 5'h01;
        if (filt_count == 5'h01) begin
            filter_clear_active <= 1'b0;
        end
    end else if (wr_init && wv[`MDAC_INIT_FILT_CLR]) begin
        filter_clear_active <= 1'b1;
        filt_count <= `MDAC_FILT_CLR_CYC;
    end else begin
        if (comb_result_valid) begin
            comb_data <= comb_result;
        end
        if (lp_load || hp_load) begin
            lphp_data <= filter_result;
        end
        if (av_load) begin
            ac_data <= average_result;
        end else if (sq_load) begin
            ac_data <= sqrt_result;
        end
    end
end

// ----------------------------------------------------------------------
// Peak hold
// ----------------------------------------------------------------------
wire dc_new = comb_result_valid && !ac_mode;
wire [31:0] ac_val = av_load ? average_result : sqrt_result;
wire ac_new = (av_load || sq_load) && ac_mode;

always @(posedge aclk) begin
    if (!aresetn) begin
        peak_clear <= 1'b0;
        peak_count <= 10'h000;
        dc_max <= `MDAC_DCMAX_RST;
        dc_min <= `MDAC_DCMIN_RST;
        ac_max <= 32'h00000000;
        ac_min <= 32'h00000000;
    end else if (peak_clear) begin
        peak_count <= peak_count - 10'h001;
        if (peak_count == 10'h001) begin
            peak_clear <= 1'b0;
            dc_max <= `MDAC_DCMAX_RST;
            dc_min <= `MDAC_DCMIN_RST;
            ac_max <= 32'h00000000;
            ac_min <= 32'h00000000;
        end
    end else if (wr_init && wv[`MDAC_INIT_PEAK_CLR]) begin
        peak_clear <= 1'b1;
        peak_count <= `MDAC_PEAK_CLR_CYC;
    end else if (peak_enable) begin
        if (dc_new && $signed(comb_result) > $signed(dc_max)) begin
            dc_max <= comb_result;
        end
        if (dc_new && $signed(comb_result) < $signed(dc_min)) begin
            dc_min <= comb_result;
        end
        if (ac_new && (ac_val > ac_max || ac_max == 32'h0)) begin
            ac_max <= ac_val;
        end
        if (ac_new && (ac_val < ac_min || ac_min == 32'h0)) begin
            ac_min <= ac_val;
        end
    end
end

// ----------------------------------------------------------------------
// AXI4-Lite slave
// ----------------------------------------------------------------------
reg [15:0] rd_val;
reg rd_hit;

always @* begin
    rd_hit = 1'b1;
    rd_val = 16'h0000;
    case (s_axi_araddr)
        `MDAC_OFS_CLOCK: rd_val = {7'h00, debug_run, 2'h0,
                                   clock_divide_sel, 2'h0, clock_source_sel};
        `MDAC_OFS_CONF: rd_val = {2'h0, average_count_sel,
            oversample_ratio_sel, sqrt_stage_enable, filter_path_select,
            peak_enable, mean_type_select, 3'h0, module_enable};
        `MDAC_OFS_FUNC: rd_val = {9'h000, range_select, function_select};
        `MDAC_OFS_INIT: rd_val = {6'h00, peak_clear, filter_clear_active,
                                  6'h00, conversion_run, 1'b0};
        `MDAC_OFS_IE: rd_val = {5'h00, irq_enable};
        `MDAC_OFS_IF: rd_val = {stage_busy, flags};
        `MDAC_OFS_COMB: rd_val = comb_data;
        `MDAC_OFS_LPHP: rd_val = lphp_data;
        `MDAC_OFS_AC1: rd_val = ac_data[15:0];
        `MDAC_OFS_AC2: rd_val = ac_data[31:16];
        `MDAC_OFS_DCMAX: rd_val = dc_max;
        `MDAC_OFS_DCMIN: rd_val = dc_min;
        `MDAC_OFS_ACMAX1: rd_val = ac_max[15:0];
        `MDAC_OFS_ACMAX2: rd_val = ac_max[31:16];
        `MDAC_OFS_ACMIN1: rd_val = ac_min[15:0];
        `MDAC_OFS_ACMIN2: rd_val = ac_min[31:16];
        `MDAC_OFS_CLKSTAT: rd_val = {12'h000, osc_sync};
        default: rd_hit = 1'b0;
    endcase
end

wire aw_known = aw_addr <= `MDAC_OFS_CLKSTAT && aw_addr[1:0] == 2'b00;

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'b00;
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rresp <= 2'b00;
        s_axi_rdata <= 32'h00000000;
        have_aw <= 1'b0;
        have_w <= 1'b0;
        wr_addr <= 8'h00;
        wr_data <= 32'h00000000;
        wr_strb <= 4'h0;
    end else begin
        s_axi_awready <= !have_aw && !s_axi_awready && !s_axi_bvalid
                         && s_axi_awvalid;
        s_axi_wready <= !have_w && !s_axi_wready && !s_axi_bvalid
                        && s_axi_wvalid;
        if (s_axi_awvalid && s_axi_awready) begin
            wr_addr <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
        if (do_write) begin
            have_aw <= 1'b0;
            have_w <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= aw_known ? 2'b00 : 2'b10;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            have_aw <= aw_ok;
            have_w <= w_ok;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
        s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_val};
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// [testbench/mdac_control_asserts.sv]
// Concurrent checks on the ports of the converter control block.
// Assumes it is bound into mdac_control and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module mdac_chk (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] clock_source_sel,
    input wire logic [4:0] clock_divide_log2,
    input wire logic [3:0] oversample_ratio_sel,
    input wire logic filter_clear_active
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ------
    // Sequences
    // ------
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_clr_start;
        $rose(filter_clear_active);
    endsequence
    a_write_resp_next:
    assert property (s_wr_taken |=> s_axi_bvalid)
        else $error("write response late");
    a_bresp_holds:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_read_data_next:
    assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_holds:
    assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data unstable");
    a_osr_code_legal:
    assert property (oversample_ratio_sel <= 4'ha)
        else $error("reserved ratio code");
    a_divide_osc_range:
    assert property (clock_source_sel == 2'h0 |-> clock_divide_log2 <= 5'h3)
        else $error("oscillator divide out of range");
    a_divide_ext_range:
    assert property (clock_source_sel != 2'h0
        |-> clock_divide_log2 inside {5'h0, 5'h2, 5'h3, 5'h4})
        else $error("source divide out of range");
    a_clear_stands:
    assert property (s_clr_start |-> filter_clear_active [*8])
        else $error("filter clear too short");
    a_clear_ends:
    assert property (s_clr_start |-> ##16 !filter_clear_active)
        else $error("filter clear length wrong");
endmodule
bind mdac_control mdac_chk u_chk (.*);
`default_nettype wire

// [testbench/mdac_chain_model.sv]
// Model of the filter chain that hands stage results to the block.
// Assumes the bench asks for results through fire and value.
`timescale 1ns/1ps
`default_nettype none
module mdac_chain_model (
    input wire logic aclk,
    input wire logic conversion_run,
    input wire logic [4:0] fire,
    input wire logic [31:0] value,
    output wire logic comb_result_valid,
    output wire logic lowpass_result_valid,
    output wire logic highpass_result_valid,
    output wire logic average_result_valid,
    output wire logic sqrt_result_valid,
    output wire logic [15:0] comb_result,
    output wire logic [15:0] filter_result,
    output wire logic [31:0] average_result,
    output wire logic [31:0] sqrt_result,
    output wire logic [4:0] stage_busy
);
    logic [4:0] busy = 5'h0;
    logic [4:0] vld = 5'h0;
    logic [31:0] held = 32'h0;
    logic [31:0] data = 32'h0;
    assign stage_busy = busy;
    assign {sqrt_result_valid, average_result_valid, highpass_result_valid,
        lowpass_result_valid, comb_result_valid} = vld;
    assign comb_result = data[15:0];
    assign filter_result = data[15:0];
    assign average_result = data;
    assign sqrt_result = data;
    // Results flow only while converting; idle data lines keep toggling.
    always @(posedge aclk) begin
        busy <= fire;
        if (|fire) begin
            held <= value;
        end
        vld <= conversion_run ? busy : 5'h0;
        data <= (|busy) ? held : ~data;
    end
endmodule
`default_nettype wire

// [testbench/mdac_control_tb.sv]
// Self-checking bench for the converter control block.
// Assumes the chain model and the bound checker beside the design.
`timescale 1ns/1ps
`default_nettype none
module mdac_control_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 32'h0, value = 32'h0, rd;
    logic [3:0] s_axi_wstrb = 4'hf, osc_running = 4'h1;
    logic debug_mode = 0, ac_mode = 0, continuity_in = 0;
    logic [4:0] fire = 5'h0;
    logic [1:0] rr;
    int n_fail = 0, compares = 0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire logic s_axi_rvalid, operating_clock_enable, conversion_run, irq;
    wire logic filter_clear_active, sqrt_stage_enable, filter_path_select;
    wire logic mean_type_select, comb_result_valid, lowpass_result_valid;
    wire logic highpass_result_valid, average_result_valid, sqrt_result_valid;
    wire logic [1:0] s_axi_bresp, s_axi_rresp, clock_source_sel;
    wire logic [1:0] average_count_sel;
    wire logic [31:0] s_axi_rdata, average_result, sqrt_result;
    wire logic [4:0] clock_divide_log2, stage_busy;
    wire logic [3:0] oversample_ratio_sel, function_select;
    wire logic [2:0] range_select;
    wire logic [15:0] comb_result, filter_result;
    mdac_control u_dut (.*);
    mdac_chain_model u_chain (.*);
    always #2.5 aclk = ~aclk;
    // ------
    // Bus and check helpers
    // ------
    task automatic chk(input string what, input logic [31:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (!s_axi_bvalid && n < 100);
        chk("bresp", 0, s_axi_bresp);
        s_axi_bready <= 1'b0;
        chk("write done", 1, n < 100);
        repeat (2) @(posedge aclk);
    endtask
    task automatic rdr(input logic [7:0] a);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (!s_axi_rvalid && n < 100);
        rd = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
        chk("read done", 1, n < 100);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, string w);
        rdr(a);
        chk("rresp", 0, rr);
        chk(w, e, rd);
    endtask
    task automatic shot(input logic [4:0] m, input logic [31:0] v);
        @(posedge aclk);
        fire <= m;
        value <= v;
        @(posedge aclk);
        fire <= 5'h0;
        repeat (6) @(posedge aclk);
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_regs;
        rc(8'h04, 32'h0, "conf reset");
        rc(8'h28, 32'h8000, "dc max reset");
        rc(8'h2c, 32'h7fff, "dc min reset");
        rdr(8'h44);
        chk("unmapped resp", 32'h2, rr);
    endtask
    task automatic t_clock;
        for (int s = 0; s < 4; s++) begin
            for (int d = 0; d < 4; d++) begin
                wr(8'h00, 32'h0100 | (d << 4) | s);
                chk("src", s, clock_source_sel);
                chk("div", (s == 0 || d == 0) ? d : d + 1, clock_divide_log2);
            end
        end
        wr(8'h04, 32'h1);
        debug_mode <= 1'b1;
        repeat (3) @(posedge aclk);
        chk("clk in debug", 1, operating_clock_enable);
        wr(8'h00, 32'h0);
        rc(8'h00, 32'h0133, "clk locked");
        wr(8'h04, 32'h0);
        chk("clk off", 0, operating_clock_enable);
        wr(8'h00, 32'h0030);
        wr(8'h04, 32'h1);
        chk("clk stop debug", 0, operating_clock_enable);
        debug_mode <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("clk run", 1, operating_clock_enable);
    endtask
    task automatic t_conf;
        for (int c = 0; c < 12; c++) begin
            wr(8'h04, ((c % 4) << 12) | (c << 8));
            chk("osr", (c > 10) ? 10 : c, oversample_ratio_sel);
            chk("avg", c % 4, average_count_sel);
        end
    endtask
    task automatic t_events;
        wr(8'h04, 32'h1);
        wr(8'h10, 32'h011);
        wr(8'h0c, 32'h2);
        chk("run", 1, conversion_run);
        shot(5'h01, 32'h1234);
        rc(8'h14, 32'h001, "comb done");
        chk("irq on", 1, irq);
        shot(5'h01, 32'h5678);
        rc(8'h14, 32'h011, "comb ovr");
        rc(8'h18, 32'h5678, "comb new");
        wr(8'h14, 32'h011);
        rc(8'h14, 32'h0, "w1c");
        chk("irq off", 0, irq);
        shot(5'h06, 32'h0042);
        rc(8'h14, 32'h004, "hp only");
        chk("irq masked", 0, irq);
        rc(8'h1c, 32'h0042, "hp result");
        shot(5'h18, 32'h1);
        shot(5'h18, 32'h2);
        rc(8'h14, 32'h08c, "avg ovr");
        rc(8'h20, 32'h2, "ac lo");
        continuity_in <= 1'b1;
        repeat (6) @(posedge aclk);
        rc(8'h14, 32'h48c, "cont");
        wr(8'h14, 32'h7ff);
        continuity_in <= 1'b0;
        repeat (6) @(posedge aclk);
        rc(8'h14, 32'h400, "cont back");
        wr(8'h04, 32'hd1);
        chk("sel bits", 7, {sqrt_stage_enable, filter_path_select, mean_type_select});
        shot(5'h1e, 32'h77);
        rc(8'h14, 32'h502, "lp and sqrt");
        rc(8'h20, 32'h77, "sqrt result");
    endtask
    task automatic t_clear;
        wr(8'h04, 32'h21);
        shot(5'h01, 32'h0100);
        shot(5'h01, 32'hff00);
        wr(8'h04, 32'h01);
        shot(5'h01, 32'h0200);
        rc(8'h28, 32'h0100, "dc max");
        rc(8'h2c, 32'hff00, "dc min");
        wr(8'h0c, 32'h0202);
        rc(8'h0c, 32'h0202, "peak clearing");
        repeat (820) @(posedge aclk);
        rc(8'h0c, 32'h0002, "peak idle");
        rc(8'h28, 32'h8000, "dc max wiped");
        wr(8'h0c, 32'h0102);
        rc(8'h0c, 32'h0102, "filter clearing");
        repeat (20) @(posedge aclk);
        chk("clear done", 0, filter_clear_active);
        rc(8'h18, 32'h0, "comb wiped");
        rc(8'h14, 32'h400, "flags wiped");
        wr(8'h0c, 32'h0100);
        wr(8'h08, 32'h0013);
        chk("func", 3, function_select);
        wr(8'h0c, 32'h0102);
        wr(8'h08, 32'h0023);
        chk("range", 2, range_select);
    endtask
    task automatic report_and_stop;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_fail++;
        report_and_stop;
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_clock;
        wr(8'h04, 32'h0);
        t_conf;
        t_events;
        t_clear;
        report_and_stop;
    end
endmodule
`default_nettype wire
